/* pwm_pkg.sv */
// constants and carrier types for the four channel spread pwm block
// assumes a 32-bit ahb-lite register bus and one system clock
package pwm_pkg;

   // counter and quadrant geometry
   localparam int CNT_W = 10;
   localparam int QUAD_W = 8;
   localparam int LSB_W = 2;
   localparam int MAX_CH = 4;
   localparam logic [CNT_W-1:0] CNT_FIRST = 10'h000;
   localparam logic [CNT_W-1:0] CNT_LAST = 10'h3FF;

   // quadrant numbers, first to fourth
   localparam logic [1:0] QUAD_1ST = 2'h0;
   localparam logic [1:0] QUAD_2ND = 2'h1;
   localparam logic [1:0] QUAD_3RD = 2'h2;
   localparam logic [1:0] QUAD_4TH = 2'h3;

   // width low-bit codes
   localparam logic [1:0] LSB_00 = 2'h0;
   localparam logic [1:0] LSB_11 = 2'h3;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CH0_LOW = 8'h88;
   localparam logic [7:0] IDX_CH0_HIGH = 8'h89;
   localparam logic [7:0] IDX_CH1_LOW = 8'h8A;
   localparam logic [7:0] IDX_CH1_HIGH = 8'h8B;
   localparam logic [7:0] IDX_CH2_LOW = 8'h8C;
   localparam logic [7:0] IDX_CH2_HIGH = 8'h8D;
   localparam logic [7:0] IDX_CH3_LOW = 8'h8E;
   localparam logic [7:0] IDX_CH3_HIGH = 8'h8F;
   localparam logic [7:0] IDX_STATUS = 8'h80;

   // address split: word index in haddr[9:2], all bits above must be zero
   localparam int ADDR_IDX_LO = 2;
   localparam int ADDR_IDX_HI = 9;

   // low-bits and high-bits register fields
   localparam int LOW_WIDTH_HI = 7;
   localparam int LOW_WIDTH_LO = 6;
   localparam int LOW_SPREAD_BIT = 0;
   localparam int HIGH_BYTE_HI = 7;

   // status register fields
   localparam int ST_CNT_LSB = 0;
   localparam int ST_OUT_LSB = 16;
   localparam int ST_PROG_LSB = 24;

   // ahb-lite codes
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;

   typedef struct packed {
      logic spread;
      logic [CNT_W-1:0] width;
   } ch_cfg_t;

   typedef struct packed {
      logic sel;
      logic write;
      logic [7:0] idx;
   } ahb_dphase_t;

endpackage

/* four_channel_spread_pwm.sv */
// four channel pulse-width modulator with optional spread mode,
// behind a zero-wait ahb-lite register slave
// assumes the prescaler pulse comes from logic on ref_clk_i and the port mux
// sits outside and routes pwm_o to the upper nibble of the port
//
// How it works
// - one free-running 10-bit counter wraps every 1024 counts and serves all four channels.
// - in normal mode an output is high for width plus one counts of every period.
// - the counter advances only on prescaler enable pulses.
// - in spread mode each period is four quadrants of 256 counts, each with its own high interval.
// - in spread mode each quadrant's base high count is the upper eight width bits.
// - quadrant one always gets one count more; the two low width bits add one count to quadrant three, then two, then four.
// - bit 0 of the low-bits register picks single block (0) or spread (1) output.
// - a low-bits write keeps bits 7:6 as the two low width bits and ignores bits 5:1.
// - a high-bits write keeps bits 7:0 as the eight upper width bits.
// - width and mode registers take no value from reset.
// - low-bits registers sit at even indices from 0x88, high-bits at the odd index above.
// - the four outputs are offered to the upper four port bits for alternate function use.
`timescale 1ns/1ns
module four_channel_spread_pwm #(
   parameter int CH_N = 4
) (
   input wire logic ref_clk_i, // system clock, 25 mhz
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic prescale_tick_i, // one-cycle enable from prescale timer
   input wire logic hsel_i, // ahb slave select
   input wire logic [31:0] haddr_i, // ahb address
   input wire logic [1:0] htrans_i, // ahb transfer type
   input wire logic hwrite_i, // ahb write
   input wire logic [2:0] hsize_i, // ahb size, word only
   input wire logic [31:0] hwdata_i, // ahb write data
   input wire logic hready_i, // ahb bus ready
   output logic [31:0] hrdata_o, // ahb read data
   output logic hreadyout_o, // ahb slave ready
   output logic hresp_o, // ahb response, always okay
   output logic [CH_N-1:0] pwm_o // modulator outputs
);

   generate
      if (CH_N < 1 || CH_N > pwm_pkg::MAX_CH) begin : g_bad_ch
         $error("CH_N must be between 1 and 4");
      end
   endgenerate

   typedef struct packed {
      pwm_pkg::ch_cfg_t [CH_N-1:0] shadow;
      pwm_pkg::ch_cfg_t [CH_N-1:0] active;
      logic [CH_N-1:0] prog;
      logic [CH_N-1:0] act_prog;
      logic [pwm_pkg::CNT_W-1:0] cnt;
      logic [CH_N-1:0] pwm;
      pwm_pkg::ahb_dphase_t dph;
      logic [31:0] rdata;
      logic ready;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic [CH_N-1:0] lvl;
   logic [31:0] status;

   // per-channel compare against the shared counter
   genvar gi;
   generate
      for (gi = 0; gi < CH_N; gi++) begin : g_ch
         pwm_pkg::ch_cfg_t a;
         logic [1:0] quad;
         logic [1:0] lsb;
         logic extra;
         logic [pwm_pkg::QUAD_W:0] quota;
         logic spread_hi;
         logic norm_hi;
         assign a = s_r.active[gi];
         assign quad = s_r.cnt[pwm_pkg::CNT_W-1 -: 2];
         assign lsb = a.width[pwm_pkg::LSB_W-1:0];
         assign extra = (quad == pwm_pkg::QUAD_1ST)
            | (quad == pwm_pkg::QUAD_2ND && lsb[1])
            | (quad == pwm_pkg::QUAD_3RD && lsb != pwm_pkg::LSB_00)
            | (quad == pwm_pkg::QUAD_4TH && lsb == pwm_pkg::LSB_11);
         // base of 255 plus the extra count fills a whole quadrant, hence nine bits
         assign quota = {1'b0, a.width[pwm_pkg::CNT_W-1:pwm_pkg::LSB_W]}
            + {{pwm_pkg::QUAD_W{1'b0}}, extra};
         assign spread_hi = {1'b0, s_r.cnt[pwm_pkg::QUAD_W-1:0]} < quota;
         assign norm_hi = s_r.cnt <= a.width;
         // an unprogrammed channel stays low rather than showing unknown levels
         assign lvl[gi] = s_r.act_prog[gi] & (a.spread ? spread_hi : norm_hi);
      end
   endgenerate

   always_comb begin
      status = '0;
      status[pwm_pkg::ST_CNT_LSB +: pwm_pkg::CNT_W] = s_r.cnt;
      status[pwm_pkg::ST_OUT_LSB +: CH_N] = s_r.pwm;
      status[pwm_pkg::ST_PROG_LSB +: CH_N] = s_r.prog;
   end

   always_comb begin
      logic [7:0] off;
      logic [1:0] ch;
      logic hit;
      off = '0;
      ch = '0;
      hit = 1'b0;
      s_nxt = s_r;
      s_nxt.ready = 1'b1;
      s_nxt.pwm = lvl;

      if (prescale_tick_i) begin
         if (s_r.cnt == pwm_pkg::CNT_LAST) begin
            s_nxt.cnt = pwm_pkg::CNT_FIRST;
            // settings only move into the compare path at the wrap
            s_nxt.active = s_r.shadow;
            s_nxt.act_prog = s_r.prog;
         end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end

      // data phase of a write
      if (s_r.dph.sel && s_r.dph.write) begin
         off = s_r.dph.idx - pwm_pkg::IDX_CH0_LOW;
         ch = off[2:1];
         hit = (s_r.dph.idx >= pwm_pkg::IDX_CH0_LOW) && (s_r.dph.idx <= pwm_pkg::IDX_CH3_HIGH)
            && (32'(ch) < CH_N);
         if (hit) begin
            if (off[0]) begin
               s_nxt.shadow[ch].width[pwm_pkg::CNT_W-1:pwm_pkg::LSB_W] =
                  hwdata_i[pwm_pkg::HIGH_BYTE_HI:0];
               s_nxt.prog[ch] = 1'b1;
            end else begin
               s_nxt.shadow[ch].width[pwm_pkg::LSB_W-1:0] =
                  hwdata_i[pwm_pkg::LOW_WIDTH_HI:pwm_pkg::LOW_WIDTH_LO];
               s_nxt.shadow[ch].spread = hwdata_i[pwm_pkg::LOW_SPREAD_BIT];
            end
         end
      end

      // address phase; zero wait so every accepted phase completes next cycle
      if (hready_i) begin
         s_nxt.dph.sel = hsel_i && htrans_i[pwm_pkg::HTRANS_ACTIVE_BIT]
            && (haddr_i[31:pwm_pkg::ADDR_IDX_HI+1] == '0)
            && (haddr_i[pwm_pkg::ADDR_IDX_LO-1:0] == '0);
         s_nxt.dph.write = hwrite_i;
         s_nxt.dph.idx = haddr_i[pwm_pkg::ADDR_IDX_HI:pwm_pkg::ADDR_IDX_LO];
         // read data only moves on an accepted address phase, so it stands
         // through the data phase until the master has taken it
         if (hsel_i && htrans_i[pwm_pkg::HTRANS_ACTIVE_BIT]) begin
            // width registers are write-only and read back as zero
            s_nxt.rdata = (s_nxt.dph.sel && !hwrite_i
               && s_nxt.dph.idx == pwm_pkg::IDX_STATUS) ? status : '0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         // widths and modes take no reset value; a data-phase write or a wrap still loads them
         s_r.shadow <= s_nxt.shadow;
         s_r.active <= s_nxt.active;
         s_r.prog <= '0;
         s_r.act_prog <= '0;
         s_r.cnt <= pwm_pkg::CNT_FIRST;
         s_r.pwm <= '0;
         s_r.dph <= '0;
         s_r.rdata <= '0;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata_o = s_r.rdata;
   assign hreadyout_o = s_r.ready;
   assign hresp_o = pwm_pkg::HRESP_OKAY;
   assign pwm_o = s_r.pwm;

   logic unused_ok;
   assign unused_ok = ^hsize_i;

endmodule

/* pwm_checker.sv */
// port assertions for the pwm block
// assumes the bind at the foot of this file
`timescale 1ns/1ns
module pwm_checker #(parameter int CH_N = 4) (
   input wire logic ref_clk_i, // clk
   input wire logic rst_n_i, // rst
   input wire logic prescale_tick_i, // tick
   input wire logic hsel_i, // sel
   input wire logic [31:0] haddr_i, // addr
   input wire logic [1:0] htrans_i, // trans
   input wire logic hwrite_i, // write
   input wire logic hready_i, // ready
   input wire logic [31:0] hrdata_o, // rdata
   input wire logic hreadyout_o, // ready out
   input wire logic hresp_o, // resp
   input wire logic [CH_N-1:0] pwm_o // pins
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire sel = hsel_i && htrans_i[1] && hready_i;
   wire rd = sel && !hwrite_i;
   a_resp_okay: assert property (!hresp_o) else $error("resp");
   a_no_wait: assert property (hreadyout_o) else $error("wait");
   a_tick_moves_pin: assert property ($changed(pwm_o) |-> $past(prescale_tick_i, 2))
      else $error("pin moved");
   a_rdata_hold: assert property (!sel |=> $stable(hrdata_o)) else $error("rdata");
   a_width_wo: assert property (rd && haddr_i[31:5] == 27'h11 |=> hrdata_o == '0)
      else $error("width read");
   a_unmapped_zero: assert property (rd && haddr_i[31:10] != 22'h0 |=> hrdata_o == '0)
      else $error("unmapped");
   a_misalign_zero: assert property (rd && haddr_i[1:0] != 2'h0 |=> hrdata_o == '0)
      else $error("misaligned");
   a_reset_quiet: assert property ($rose(rst_n_i) |-> pwm_o == '0) else $error("reset");
endmodule
bind four_channel_spread_pwm pwm_checker #(.CH_N(CH_N)) chk_u (.ref_clk_i, .rst_n_i,
   .prescale_tick_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
   .hreadyout_o, .hresp_o, .pwm_o);

/* filter_model.sv */
// far-side model: per pin, high cycles and pulse starts since the last clear
// counts hold at any counter phase, so the bench need not align to it
`timescale 1ns/1ns
module filter_model (
   input wire logic ref_clk_i, // clk
   input wire logic clear_i, // new window
   input wire logic [3:0] pin_i, // pins
   output int high_o [4], // high cycles
   output int rise_o [4] // pulses
);
   logic [3:0] last_r;
   always @(posedge ref_clk_i) begin
      last_r <= pin_i;
      for (int i = 0; i < 4; i++) begin
         high_o[i] <= clear_i ? 0 : high_o[i] + int'(pin_i[i] === 1'b1);
         rise_o[i] <= clear_i ? 0 : rise_o[i] + int'(pin_i[i] && !last_r[i]);
      end
   end
endmodule

/* testbench.sv */
// bench: random and corner widths on all channels, judged at the pins
// assumes the checker bind and the filter model compile with the design
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, hwrite = 1'b0, clr = 1'b0, hrdy;
   logic [1:0] htrans = 2'h0;
   logic [3:0] pwm;
   logic [9:0] w [4], c0, n;
   logic s [4];
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [31:0] addrs [4] = '{32'h220, 32'h23C, 32'h222, 32'h400};
   int high_n [4], rise_n [4];
   int mismatches = 0, total_checks = 0, cycles = 0, seed = 32'h294B;
   always #20 clk = ~clk;
   four_channel_spread_pwm dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .prescale_tick_i(tick),
      .hsel_i(htrans[1]), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
      .hreadyout_o(hrdy), .hresp_o(), .pwm_o(pwm));
   filter_model flt_u (.ref_clk_i(clk), .clear_i(clr), .pin_i(pwm), .high_o(high_n),
      .rise_o(rise_n));
   task automatic check(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic ahb(input logic wr, input logic [31:0] a, d);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic measure();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (1024) @(posedge clk);
      #1;
   endtask
   function automatic int rises(logic [9:0] v, logic sp);
      return !sp ? int'(v != 10'h3FF) : (v[9:2] != 8'h0) ? 4 : int'(v[1:0]) + 1;
   endfunction
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tick <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         for (int ch = 0; ch < 4; ch++) begin
            w[ch] = (r == 2) ? {10{ch[1]}} : 10'($random(seed));
            s[ch] = (r == 1) || ch[0];
            if (r == 1)
               w[ch][1:0] = 2'(ch);
            // spread base kept below 255 so no quadrant is high throughout
            if (s[ch])
               w[ch] = w[ch] & 10'h3FB;
            ahb(1'b1, 32'h220 + 32'h8 * ch, {24'h0, w[ch][1:0], 5'($random(seed)), s[ch]});
            ahb(1'b1, 32'h224 + 32'h8 * ch, {24'h0, w[ch][9:2]});
         end
         ahb(1'b1, r[0] ? 32'h226 : 32'h624, 32'hFF);
         repeat (1100) @(posedge clk);
         measure();
         for (int ch = 0; ch < 4; ch++) begin
            check(high_n[ch], w[ch] + 32'h1);
            check(rise_n[ch], rises(w[ch], s[ch]));
         end
      end
      tick <= 1'b0;
      measure();
      check(rise_n[0], 32'h0);
      ahb(1'b0, 32'h200, 32'h0);
      c0 = rd[9:0];
      n = 10'($random(seed)) | 10'h200;
      tick <= 1'b1;
      repeat (n) @(posedge clk);
      tick <= 1'b0;
      ahb(1'b0, 32'h200, 32'h0);
      check(rd[9:0], 10'(c0 + n));
      foreach (addrs[i]) begin
         ahb(1'b0, addrs[i], 32'h0);
         check(rd, 32'h0);
      end
      stop_test();
   end
endmodule
